// File: verilog/slow_osc_config.v
// Slow oscillator configuration register and clock source selection.
// Assumes a simple synchronous register port and free-running source clocks.
`timescale 1ns/1ns
`default_nettype none
`include "slow_osc_map.vh"
module slow_osc_config #(
	parameter [31:0] STABLE_WAIT_CYCLES = `STABLE_WAIT_CYCLES,
	parameter [7:0] FAST_DIV = `FAST_DIV_RATIO
) (
	input wire i_core_clk,
	input wire i_sys_rst,
	input wire i_reg_wr,
	input wire i_reg_rd,
	input wire [31:0] i_reg_addr,
	input wire [31:0] i_reg_wdata,
	input wire i_slow_osc_ready,
	input wire i_sleep_fast_osc_powerdown,
	input wire i_fast_osc_clk,
	input wire i_slow_osc_clk,
	output reg [31:0] o_reg_rdata,
	output wire o_slow_osc_enable_request,
	output wire o_slow_osc_stable_flag,
	output wire o_sleep_fast_osc_powerdown,
	output wire o_rtc_pm_clk
);
	// Ready indication passes two flip-flops before use
	localparam SYNC_STAGES = 2;
	localparam [7:0] HALF_DIV = FAST_DIV >> 1;
	localparam [31:0] LAST_WAIT = STABLE_WAIT_CYCLES - 32'h00000001;

	// Register storage and next values
	reg [31:0] core_clock_config_q;
	reg [31:0] core_clock_config_d;
	reg [31:0] unit_clock_enable_q;
	reg [31:0] unit_clock_enable_d;
	reg enable_q;
	reg enable_d;
	reg stable_q;
	reg stable_d;
	reg [31:0] wait_q;
	reg [31:0] wait_d;
	reg [SYNC_STAGES-1:0] ready_sync_q;
	reg [31:0] rdata_d;
	wire ready_synced;
	wire wait_open;

	// Divider and clock mux
	reg [7:0] div_cnt_q;
	reg [7:0] div_cnt_d;
	reg div_clk_q;
	reg div_clk_d;
	reg [1:0] sel_fast_q;
	reg [1:0] sel_fast_d;
	reg [1:0] sel_slow_q;
	reg [1:0] sel_slow_d;
	reg gate_fast_q;
	reg gate_fast_d;
	reg gate_slow_q;
	reg gate_slow_d;
	wire want_fast;
	wire want_slow;
	wire div_wrap;

	// Exact address match
	function hit;
		input [31:0] addr;
		input [31:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	// Register decodes
	wire wr_core = i_reg_wr & hit(i_reg_addr, `CORE_CLOCK_CONFIG_ADDR);
	wire wr_unit = i_reg_wr & hit(i_reg_addr, `UNIT_CLOCK_ENABLE_ADDR);
	wire wr_osc = i_reg_wr & hit(i_reg_addr, `SLOW_OSC_CONFIG_ADDR);
	wire rd_core = i_reg_rd & hit(i_reg_addr, `CORE_CLOCK_CONFIG_ADDR);
	wire rd_unit = i_reg_rd & hit(i_reg_addr, `UNIT_CLOCK_ENABLE_ADDR);
	wire rd_osc = i_reg_rd & hit(i_reg_addr, `SLOW_OSC_CONFIG_ADDR);

	// Ready synchroniser
	genvar g;
	generate
		for (g = 0; g < SYNC_STAGES; g = g + 1) begin : gen_sync
			if (g == 0) begin : gen_first
				always @(posedge i_core_clk) begin
					if (i_sys_rst) begin
						ready_sync_q[g] <= 1'b0;
					end else begin
						ready_sync_q[g] <= i_slow_osc_ready;
					end
				end
			end else begin : gen_next
				always @(posedge i_core_clk) begin
					if (i_sys_rst) begin
						ready_sync_q[g] <= 1'b0;
					end else begin
						ready_sync_q[g] <= ready_sync_q[g-1];
					end
				end
			end
		end
	endgenerate

	assign ready_synced = ready_sync_q[SYNC_STAGES-1];

	// Plain storage registers
	always @* begin
		core_clock_config_d = core_clock_config_q;
		if (wr_core) begin
			core_clock_config_d = i_reg_wdata;
		end
	end

	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			core_clock_config_q <= `CORE_CLOCK_CONFIG_RST;
		end else begin
			core_clock_config_q <= core_clock_config_d;
		end
	end

	always @* begin
		unit_clock_enable_d = unit_clock_enable_q;
		if (wr_unit) begin
			unit_clock_enable_d = i_reg_wdata;
		end
	end

	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			unit_clock_enable_q <= `UNIT_CLOCK_ENABLE_RST;
		end else begin
			unit_clock_enable_q <= unit_clock_enable_d;
		end
	end

	// Set-only enable request
	always @* begin
		enable_d = enable_q;
		if (wr_osc & i_reg_wdata[`SLOW_OSC_EN_BIT]) begin
			enable_d = 1'b1;
		end
	end

	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			enable_q <= 1'b0;
		end else begin
			enable_q <= enable_d;
		end
	end

	// Settling budget, counted while enabled and not yet stable
	assign wait_open = (wait_q < LAST_WAIT);
	always @* begin
		wait_d = wait_q;
		if (enable_q & ~stable_q & ~ready_synced & wait_open) begin
			wait_d = wait_q + 32'h00000001;
		end
	end

	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			wait_q <= 32'h00000000;
		end else begin
			wait_q <= wait_d;
		end
	end

	// Stable once ready is seen or the budget runs out
	always @* begin
		stable_d = stable_q;
		if (enable_q & ~stable_q) begin
			if (ready_synced | ~wait_open) begin
				stable_d = 1'b1;
			end
		end
	end

	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			stable_q <= 1'b0;
		end else begin
			stable_q <= stable_d;
		end
	end

	// Read mux, zero for unmapped addresses
	always @* begin
		rdata_d = o_reg_rdata;
		if (i_reg_rd) begin
			rdata_d = 32'h00000000;
		end
		if (rd_core) begin
			rdata_d = core_clock_config_q;
		end
		if (rd_unit) begin
			rdata_d = unit_clock_enable_q;
		end
		if (rd_osc) begin
			rdata_d = 32'h00000000;
			rdata_d[`SLOW_OSC_EN_BIT] = enable_q;
			rdata_d[`SLOW_OSC_OK_BIT] = stable_q;
		end
	end

	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_reg_rdata <= 32'h00000000;
		end else begin
			o_reg_rdata <= rdata_d;
		end
	end

	// Status outputs
	assign o_slow_osc_enable_request = enable_q;
	assign o_slow_osc_stable_flag = stable_q;
	assign o_sleep_fast_osc_powerdown = i_sleep_fast_osc_powerdown & stable_q;

	// Fast divider; reset is asynchronous as its clock is unrelated
	assign div_wrap = (div_cnt_q == HALF_DIV - 8'h01);

	always @* begin
		div_cnt_d = div_cnt_q + 8'h01;
		if (div_wrap) begin
			div_cnt_d = 8'h00;
		end
	end

	always @(posedge i_fast_osc_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			div_cnt_q <= 8'h00;
		end else begin
			div_cnt_q <= div_cnt_d;
		end
	end

	always @* begin
		div_clk_d = div_clk_q;
		if (div_wrap) begin
			div_clk_d = ~div_clk_q;
		end
	end

	always @(posedge i_fast_osc_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			div_clk_q <= 1'b0;
		end else begin
			div_clk_q <= div_clk_d;
		end
	end

	// Break-before-make mux, each select synchronised in its own domain
	assign want_fast = ~stable_q & ~gate_slow_q;
	assign want_slow = stable_q & ~gate_fast_q;

	always @* begin
		sel_fast_d = {sel_fast_q[0], want_fast};
	end

	always @(posedge div_clk_q or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sel_fast_q <= 2'h0;
		end else begin
			sel_fast_q <= sel_fast_d;
		end
	end

	always @* begin
		gate_fast_d = sel_fast_q[1];
	end

	always @(negedge div_clk_q or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			gate_fast_q <= 1'b0;
		end else begin
			gate_fast_q <= gate_fast_d;
		end
	end

	always @* begin
		sel_slow_d = {sel_slow_q[0], want_slow};
	end

	always @(posedge i_slow_osc_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sel_slow_q <= 2'h0;
		end else begin
			sel_slow_q <= sel_slow_d;
		end
	end

	always @* begin
		gate_slow_d = sel_slow_q[1];
	end

	always @(negedge i_slow_osc_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			gate_slow_q <= 1'b0;
		end else begin
			gate_slow_q <= gate_slow_d;
		end
	end

	// Only one gate is open, except if stable_q rises while a 1 sits in sel_fast_q before gate_fast_q
	assign o_rtc_pm_clk = (div_clk_q & gate_fast_q) |
		(i_slow_osc_clk & gate_slow_q);
endmodule // slow_osc_config
`default_nettype wire

// File: common/slow_osc_map.vh
// Address map, fields and timing constants of the slow oscillator config.
// Included by the design; holds definitions only.
`ifndef SLOW_OSC_MAP_VH
`define SLOW_OSC_MAP_VH
`define CORE_CLOCK_CONFIG_ADDR 32'h41300000
`define UNIT_CLOCK_ENABLE_ADDR 32'h41300004
`define SLOW_OSC_CONFIG_ADDR 32'h41300008
`define SLOW_OSC_EN_BIT 1
`define SLOW_OSC_OK_BIT 0
`define CORE_CLOCK_CONFIG_RST 32'h00000000
`define UNIT_CLOCK_ENABLE_RST 32'h00000000
`define FAST_DIV_RATIO 112
`define CORE_CLK_HZ 250000000
`define STABLE_WAIT_S 10
`define STABLE_WAIT_CYCLES (`STABLE_WAIT_S * `CORE_CLK_HZ)
`endif

// File: verif/slow_osc_config_assertions.sv
// Port checker of the slow oscillator config, bound into every instance.
`timescale 1ns/1ns
`default_nettype none
module slow_osc_chk(input wire i_core_clk,i_sys_rst,i_reg_wr,i_reg_rd,
i_sleep_fast_osc_powerdown,o_slow_osc_enable_request,
o_slow_osc_stable_flag,o_sleep_fast_osc_powerdown,
input wire [31:0] i_reg_addr,i_reg_wdata,o_reg_rdata);
	wire en=o_slow_osc_enable_request,ok=o_slow_osc_stable_flag;
	wire osc=i_reg_addr==32'h41300008;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	a_en_set: assert property(i_reg_wr&&osc&&i_reg_wdata[1]|=>en)
		else $error("enable not set");
	a_en_keep: assert property(en|=>en) else $error("enable lost");
	a_en_cause: assert property($rose(en)|->$past(i_reg_wr))
		else $error("enable rose alone");
	a_ok_en: assert property(ok|->en) else $error("stable early");
	a_ok_keep: assert property(ok|=>ok) else $error("stable lost");
	a_pd_mask: assert property(o_sleep_fast_osc_powerdown==
		(i_sleep_fast_osc_powerdown&&ok)) else $error("power-down");
	a_osc_read: assert property(i_reg_rd&&osc|=>
		o_reg_rdata=={30'h0,$past(en),$past(ok)}) else $error("read");
	a_unmapped: assert property(i_reg_rd&&i_reg_addr>32'h41300008|=>
		o_reg_rdata==32'h0) else $error("unmapped");
	c_ok: cover property($rose(ok));
	c_pd: cover property(i_sleep_fast_osc_powerdown&&!ok);
	c_rd: cover property(i_reg_rd&&osc&&ok);
endmodule // slow_osc_chk
bind slow_osc_config slow_osc_chk slow_osc_chk_i(.*);
`default_nettype wire

// File: verif/slow_xtal_model.sv
// Slow crystal model; stopped when off, ready some core cycles after enable.
`timescale 1ns/1ns
`default_nettype none
module slow_xtal_model(input wire i_clk,i_on,output logic o_clk=0,o_ready=0);
	int n=0;
	always #15 o_clk=i_on&~o_clk;
	always @(posedge i_clk) begin n<=i_on?n+1:0; o_ready<=n>8; end
endmodule // slow_xtal_model
`default_nettype wire

// File: verif/slow_osc_config_tb.sv
// Bench of the slow oscillator config; fast clock and crystal made here.
`timescale 1ns/1ns
`default_nettype none
module slow_osc_config_tb;
	localparam osc=32'h41300008;
	logic i_core_clk=0,i_sys_rst=1,i_reg_wr=0,i_reg_rd=0,i_fast_osc_clk=0;
	logic i_sleep_fast_osc_powerdown=1;
	logic [31:0] i_reg_addr=32'h0,i_reg_wdata=32'h0;
	wire [31:0] o_reg_rdata;
	wire o_slow_osc_enable_request,o_slow_osc_stable_flag,o_rtc_pm_clk,
		o_sleep_fast_osc_powerdown,i_slow_osc_clk,i_slow_osc_ready;
	int mismatches=0,comparisons=0,edges=0;
	always #2 i_core_clk=~i_core_clk;
	always #7 i_fast_osc_clk=~i_fast_osc_clk;
	always @(posedge o_rtc_pm_clk) edges++;
	slow_osc_config #(.STABLE_WAIT_CYCLES(20)) slow_osc_config_i(.*);
	slow_xtal_model slow_xtal_model_i(.i_clk(i_core_clk),
		.i_on(o_slow_osc_enable_request),.o_clk(i_slow_osc_clk),
		.o_ready(i_slow_osc_ready));
	task chk(string n,logic [31:0] s,e);
		comparisons++;
		if(s!==e) begin mismatches++; $display("BAD %s exp %h got %h",n,e,s); end
	endtask
	task acc(logic w,logic [31:0] ad,dt);
		{i_reg_wr,i_reg_rd,i_reg_addr,i_reg_wdata}<={w,!w,ad,dt};
		@(posedge i_core_clk) {i_reg_wr,i_reg_rd}<=2'h0;
		repeat(2) @(posedge i_core_clk); if(!w) chk("rdata",o_reg_rdata,dt);
	endtask
	// Many edges only when the slow crystal drives the output
	task span(int n,logic e);
		edges=0; repeat(n) @(posedge i_core_clk); chk("rtc",edges>9,e);
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d",comparisons,mismatches);
		if(mismatches==0&&comparisons>0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin #12000; mismatches++; test_done; end
	initial begin
		repeat(3) @(posedge i_core_clk); i_sys_rst<=0;
		acc(0,osc,32'h0);
		acc(0,osc+4,32'h0);
		acc(1,osc,32'h1); acc(0,osc,32'h0);
		span(150,0);
		acc(1,osc,32'h2); acc(0,osc,32'h2);
		acc(1,osc,32'h0); span(30,0); acc(0,osc,32'h3);
		repeat(1000) @(posedge i_core_clk);
		span(150,1);
		i_sys_rst<=1; repeat(3) @(posedge i_core_clk); i_sys_rst<=0;
		acc(0,osc,32'h0);
		test_done;
	end
endmodule // slow_osc_config_tb
`default_nettype wire
